// ==== irq_pkg.sv ====
// package: constants and carrier types for the free-fall / motion interrupt block
package irq_pkg;

  // ************************************************************
  // widths and factory defaults
  // ************************************************************
  localparam int SAMPLE_W = 12;
  localparam int CFG_W = 8;
  // factory defaults (plain values, fixed constants in this package)
  localparam logic [CFG_W-1:0] FF_THRESH_DEF = 8'h50;
  localparam logic [CFG_W-1:0] FF_DELAY_DEF = 8'h14;
  localparam logic [CFG_W-1:0] MOT_THRESH_DEF = 8'hC0;
  localparam logic [CFG_W-1:0] MOT_DELAY_DEF = 8'h02;
  // thresholds compare against the upper byte of the sample
  localparam int THR_SHIFT = SAMPLE_W - CFG_W;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z;
  } sample_t;

  typedef struct packed {
    logic [CFG_W-1:0] thresh;
    logic [CFG_W-1:0] delay;
    logic latch_en;
  } det_cfg_t;

endpackage : irq_pkg

// ==== debounce_det.sv ====
// module: one persistence detector with latched or unlatched indication
`timescale 1ns/1ns
`default_nettype none
module debounce_det (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic sample_en,
  input wire logic cond,
  input wire logic latch_en,
  input wire logic clear,
  input wire logic [irq_pkg::CFG_W-1:0] delay,
  // result
  output logic irq_q
);

  logic [irq_pkg::CFG_W-1:0] cnt_q;
  logic [irq_pkg::CFG_W-1:0] cnt_d;
  logic irq_d;
  wire logic reached = cond && (cnt_q >= delay);

  // condition broken restarts the count from zero
  assign cnt_d = !cond ? '0 : (reached ? cnt_q : cnt_q + 1'b1);
  // latched: hold until clear; a new event wins over the clear
  assign irq_d = reached ? 1'b1 : ((latch_en && !clear) ? irq_q : 1'b0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      irq_q <= 1'b0;
    end else if (sample_en) begin
      cnt_q <= cnt_d;
      irq_q <= irq_d;
    end else if (clear && !latch_en) begin
      irq_q <= irq_q;
    end else if (clear) begin
      irq_q <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_break_restarts: assert property (@(posedge clk) disable iff (!rst_b)
    sample_en && !cond |=> cnt_q == '0) else $error("count not restarted");
  a_latch_holds: assert property (@(posedge clk) disable iff (!rst_b)
    latch_en && irq_q && !clear && $stable(latch_en) |=> irq_q)
    else $error("latched indication dropped");

endmodule : debounce_det
`default_nettype wire

// ==== freefall_motion_interrupt.sv ====
// module: free-fall and motion interrupt logic of a three-axis sensor
`timescale 1ns/1ns
`default_nettype none
module freefall_motion_interrupt (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // device enable pin and motion gate pin
  input wire logic dev_enable,
  input wire logic motion_gate_input,
  // sample stream from the converter, same clock
  input wire logic sample_valid,
  input wire irq_pkg::sample_t sample,
  // configuration writes, same clock
  input wire logic ff_cfg_wr,
  input wire irq_pkg::det_cfg_t ff_cfg_in,
  input wire logic mot_cfg_wr,
  input wire irq_pkg::det_cfg_t mot_cfg_in,
  input wire logic ff_clear,
  input wire logic mot_clear,
  // indications
  output logic freefall_irq,
  output logic motion_irq,
  output logic combined_irq_pin
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic en_s1_q, en_s2_q, en_s3_q;
  logic gate_s1_q, gate_s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
    end else begin
      en_s1_q <= dev_enable;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      gate_s1_q <= motion_gate_input;
      gate_s2_q <= gate_s1_q;
    end
  end

  wire logic enable_rise = en_s2_q && !en_s3_q;
  wire logic running = en_s2_q;

  // ************************************************************
  // settings, one set per detector
  // ************************************************************
  localparam irq_pkg::det_cfg_t FF_DEF = '{irq_pkg::FF_THRESH_DEF, irq_pkg::FF_DELAY_DEF, 1'b0};
  localparam irq_pkg::det_cfg_t MOT_DEF = '{irq_pkg::MOT_THRESH_DEF, irq_pkg::MOT_DELAY_DEF, 1'b0};

  irq_pkg::det_cfg_t ff_cfg_q, mot_cfg_q;

  // reset and enable rise load defaults, unlatched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_cfg_q <= FF_DEF;
      mot_cfg_q <= MOT_DEF;
    end else if (enable_rise) begin
      ff_cfg_q <= FF_DEF;
      mot_cfg_q <= MOT_DEF;
    end else if (running) begin
      if (ff_cfg_wr) begin
        ff_cfg_q <= ff_cfg_in;
      end
      if (mot_cfg_wr) begin
        mot_cfg_q <= mot_cfg_in;
      end
    end
  end

  // ************************************************************
  // comparisons on the upper byte of each axis
  // ************************************************************
  wire logic [irq_pkg::CFG_W-1:0] x_hi = sample.x[irq_pkg::SAMPLE_W-1:irq_pkg::THR_SHIFT];
  wire logic [irq_pkg::CFG_W-1:0] y_hi = sample.y[irq_pkg::SAMPLE_W-1:irq_pkg::THR_SHIFT];
  wire logic [irq_pkg::CFG_W-1:0] z_hi = sample.z[irq_pkg::SAMPLE_W-1:irq_pkg::THR_SHIFT];

  wire logic ff_cond = (x_hi < ff_cfg_q.thresh) && (y_hi < ff_cfg_q.thresh)
    && (z_hi < ff_cfg_q.thresh);
  wire logic mot_cond = (x_hi > mot_cfg_q.thresh) || (y_hi > mot_cfg_q.thresh)
    || (z_hi > mot_cfg_q.thresh);

  // standby freezes detection; samples only count while enabled
  wire logic step = sample_valid && running;

  logic ff_det, mot_det;

  // ************************************************************
  // detectors
  // ************************************************************
  debounce_det u_ff (
    .clk(clk),
    .rst_b(rst_b),
    .sample_en(step),
    .cond(ff_cond),
    .latch_en(ff_cfg_q.latch_en),
    .clear(ff_clear || enable_rise),
    .delay(ff_cfg_q.delay),
    .irq_q(ff_det)
  );

  debounce_det u_mot (
    .clk(clk),
    .rst_b(rst_b),
    .sample_en(step),
    .cond(mot_cond),
    .latch_en(mot_cfg_q.latch_en),
    .clear(mot_clear || enable_rise),
    .delay(mot_cfg_q.delay),
    .irq_q(mot_det)
  );

  // ************************************************************
  // outputs, registered
  // ************************************************************
  wire logic pin_d = ff_det || (mot_det && gate_s2_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freefall_irq <= 1'b0;
      motion_irq <= 1'b0;
      combined_irq_pin <= 1'b0;
    end else begin
      freefall_irq <= ff_det;
      motion_irq <= mot_det;
      combined_irq_pin <= pin_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_pin_or_logic: assert property (@(posedge clk) disable iff (!rst_b)
    combined_irq_pin == ($past(ff_det) || ($past(mot_det) && $past(gate_s2_q))))
    else $error("pin does not follow indications");
  a_gate_blocks_motion: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(gate_s2_q) && !$past(ff_det) |-> !combined_irq_pin)
    else $error("motion passed closed gate");
  a_ff_follows_det: assert property (@(posedge clk) disable iff (!rst_b)
    ff_det |=> freefall_irq) else $error("free-fall not shown");
  a_ff_needs_cond: assert property (@(posedge clk) disable iff (!rst_b)
    step && !ff_cond && !ff_cfg_q.latch_en |=> !ff_det)
    else $error("free-fall without low condition");
  a_ff_unlatched_drop: assert property (@(posedge clk) disable iff (!rst_b)
    step && !ff_cond && !ff_cfg_q.latch_en |=> ##1 !freefall_irq)
    else $error("unlatched free-fall stuck");
  a_mot_needs_cond: assert property (@(posedge clk) disable iff (!rst_b)
    step && !mot_cond && !mot_cfg_q.latch_en |=> !mot_det)
    else $error("motion without high condition");
  a_mot_unlatched_drop: assert property (@(posedge clk) disable iff (!rst_b)
    step && !mot_cond && !mot_cfg_q.latch_en |=> ##1 !motion_irq)
    else $error("unlatched motion stuck");
  a_rise_defaults: assert property (@(posedge clk) disable iff (!rst_b)
    enable_rise |=> ff_cfg_q == FF_DEF && mot_cfg_q == MOT_DEF)
    else $error("defaults not loaded");
  a_cfg_separate: assert property (@(posedge clk) disable iff (!rst_b)
    running && !enable_rise && ff_cfg_wr && !mot_cfg_wr |=> $stable(mot_cfg_q))
    else $error("free-fall write touched motion");
  a_ff_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
    running && !enable_rise && ff_cfg_wr |=> ff_cfg_q == $past(ff_cfg_in))
    else $error("free-fall settings not written");
  a_mot_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
    running && !enable_rise && mot_cfg_wr |=> mot_cfg_q == $past(mot_cfg_in))
    else $error("motion settings not written");

  c_freefall: cover property (@(posedge clk) disable iff (!rst_b) $rose(freefall_irq));
  c_motion_pin: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(combined_irq_pin) && !freefall_irq);
  c_latched_clear: cover property (@(posedge clk) disable iff (!rst_b)
    ff_cfg_q.latch_en && ff_clear && ff_det);

endmodule : freefall_motion_interrupt
`default_nettype wire

// ==== host_monitor.sv ====
// host side model: counts rising edges seen on the shared interrupt pin
`timescale 1ns/1ns
`default_nettype none
module host_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched pin
  input wire logic irq_pin,
  // result
  output logic [7:0] rise_count
);
  logic last_q;
  // the host samples the pin once a clock, so pulses shorter than that are missed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= 1'b0;
      rise_count <= 8'h00;
    end else begin
      last_q <= irq_pin;
      if (irq_pin && !last_q) rise_count <= rise_count + 8'h01;
    end
  end
endmodule : host_monitor
`default_nettype wire

// ==== freefall_motion_interrupt_bench.sv ====
// testbench: free-fall and motion interrupt scenarios with fixed expectations
`timescale 1ns/1ns
`default_nettype none
module freefall_motion_interrupt_bench;
  // *****
  // stimulus and wiring
  // *****
  localparam logic [11:0] L = 12'h400;
  localparam logic [11:0] M = 12'h800;
  localparam logic [11:0] H = 12'hD00;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic dev_enable = 1'b0;
  logic motion_gate_input = 1'b0;
  logic sample_valid = 1'b0;
  irq_pkg::sample_t sample = '0;
  logic ff_cfg_wr = 1'b0;
  irq_pkg::det_cfg_t ff_cfg_in = '0;
  logic mot_cfg_wr = 1'b0;
  irq_pkg::det_cfg_t mot_cfg_in = '0;
  logic ff_clear = 1'b0;
  logic mot_clear = 1'b0;
  logic ff_o;
  logic mot_o;
  logic pin_o;
  logic [7:0] rises;
  int bad_count = 0;
  int checks = 0;
  always #20 clk = ~clk;
  freefall_motion_interrupt u_dut (.clk(clk), .rst_b(rst_b), .dev_enable(dev_enable),
    .motion_gate_input(motion_gate_input), .sample_valid(sample_valid), .sample(sample),
    .ff_cfg_wr(ff_cfg_wr), .ff_cfg_in(ff_cfg_in), .mot_cfg_wr(mot_cfg_wr),
    .mot_cfg_in(mot_cfg_in), .ff_clear(ff_clear), .mot_clear(mot_clear),
    .freefall_irq(ff_o), .motion_irq(mot_o), .combined_irq_pin(pin_o));
  host_monitor u_host (.clk(clk), .rst_b(rst_b), .irq_pin(pin_o), .rise_count(rises));
  // *****
  // shared tasks
  // *****
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk
  task chk_count(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk_count
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // one sample, then wait until its result has reached the outputs
  task put(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    sample_valid = 1'b1;
    sample = '{x, y, z};
    @(negedge clk);
    sample_valid = 1'b0;
    idle(2);
  endtask : put
  task cfg(input logic ff, input irq_pkg::det_cfg_t v);
    if (ff) begin
      ff_cfg_wr = 1'b1;
      ff_cfg_in = v;
    end else begin
      mot_cfg_wr = 1'b1;
      mot_cfg_in = v;
    end
    @(negedge clk);
    if (ff) ff_cfg_wr = 1'b0;
    else mot_cfg_wr = 1'b0;
  endtask : cfg
  task clr(input logic ff);
    if (ff) ff_clear = 1'b1;
    else mot_clear = 1'b1;
    @(negedge clk);
    if (ff) ff_clear = 1'b0;
    else mot_clear = 1'b0;
    idle(2);
  endtask : clr
  // *****
  // scenarios
  // *****
  task t_defaults;
    motion_gate_input = 1'b1;
    idle(3);
    repeat (20) put(L, L, L);
    chk(ff_o, 1'b0, "ff early");
    put(L, L, L);
    chk(ff_o, 1'b1, "ff set");
    chk(pin_o, 1'b1, "pin ff");
    put(L, L, 12'h500);
    chk(ff_o, 1'b0, "ff drop");
    chk(pin_o, 1'b0, "pin idle");
    put(H, M, M);
    put(M, H, M);
    chk(mot_o, 1'b0, "mot early");
    repeat (3) put(M, M, H);
    chk(mot_o, 1'b1, "mot set");
    chk(pin_o, 1'b1, "pin gated on");
    motion_gate_input = 1'b0;
    idle(4);
    chk(pin_o, 1'b0, "pin gated off");
    put(M, M, M);
    chk(mot_o, 1'b0, "mot drop");
    $display("test defaults done");
  endtask : t_defaults
  task t_restart;
    cfg(1'b1, '{8'h50, 8'h03, 1'b0});
    repeat (3) put(L, L, L);
    put(M, L, L);
    repeat (3) put(L, L, L);
    chk(ff_o, 1'b0, "ff restart");
    put(L, L, L);
    chk(ff_o, 1'b1, "ff delay 3");
    put(M, M, M);
    $display("test restart done");
  endtask : t_restart
  task t_latch;
    cfg(1'b1, '{8'h30, 8'h00, 1'b1});
    cfg(1'b0, '{8'h90, 8'h00, 1'b1});
    put(L, L, L);
    chk(ff_o, 1'b0, "ff thresh 30");
    put(12'h2F0, 12'h2F0, 12'h2F0);
    chk(ff_o, 1'b1, "ff latch set");
    put(12'hA00, M, M);
    chk(ff_o, 1'b1, "ff held");
    chk(mot_o, 1'b1, "mot thresh 90");
    chk(pin_o, 1'b1, "pin ff latched");
    clr(1'b1);
    chk(ff_o, 1'b0, "ff cleared");
    chk(mot_o, 1'b1, "mot held");
    clr(1'b0);
    chk(mot_o, 1'b0, "mot cleared");
    $display("test latch done");
  endtask : t_latch
  task t_enable;
    put(12'h2F0, 12'h2F0, 12'h2F0);
    chk(ff_o, 1'b1, "ff before rise");
    dev_enable = 1'b0;
    idle(4);
    dev_enable = 1'b1;
    idle(5);
    chk(ff_o, 1'b0, "ff after rise");
    put(L, L, L);
    chk(ff_o, 1'b0, "default delay");
    chk_count(rises, 8'h05, "host edge count");
    $display("test enable done");
  endtask : t_enable
  initial begin
    #200000;
    bad_count++;
    $display("MISMATCH %0t watchdog", $time);
    wrap_up();
  end
  initial begin
    idle(20);
    rst_b = 1'b1;
    idle(2);
    dev_enable = 1'b1;
    idle(5);
    t_defaults();
    t_restart();
    t_latch();
    t_enable();
    wrap_up();
  end
endmodule : freefall_motion_interrupt_bench
`default_nettype wire
